// >>> logic/byte_load_cfg.svh
// opcode codes, decode masks, field positions and reset values
`ifndef BYTE_LOAD_CFG_SVH
`define BYTE_LOAD_CFG_SVH

`define OP_PREFIX 8'hce
`define OP_PAGE_X 8'hc6
`define OP_PAGE_Y 8'hc7
`define OP_ST_BR_IMM 8'hdd
`define OP_ST_HL_IMM 8'hb5
`define OP_ST_IR_IMM 8'hb6
`define OP_LD_BR 8'h44
`define OP_LD_HL 8'h45
`define OP_CP_BR_HL 8'h6c
`define OP_CP_BR_IR 8'h64
`define OP_CP_HL_BR 8'h7d
`define OP_CP_HL_HL 8'h6d
`define OP_CP_HL_IR 8'h65
`define OP_LD_ABS 8'hd0

`define MASK_REG 8'he7
`define MASK_IR_PTR 8'hef
`define MASK_IR_IMM 8'hfe
`define MASK_ABS 8'hfc

`define REG_FIELD_HI 4
`define REG_FIELD_LO 3
`define ABS_FIELD_HI 1
`define ABS_FIELD_LO 0
`define IR_BIT_PTR 4
`define IR_BIT_IMM 0
`define PAGE_SEL_BIT 0

`define PAGE_RESET 8'h00
`define SMALL_PAGE 8'h00
`define BYTE_RESET 8'h00
`define ADDR_RESET 16'h0000

`endif

// >>> logic/byte_load_pkg.sv
// types shared by the byte load decoder
package byte_load_pkg;

    typedef enum logic [5:0] {
        S_OP  = 6'b000001,
        S_PFX = 6'b000010,
        S_B1  = 6'b000100,
        S_B2  = 6'b001000,
        S_RD  = 6'b010000,
        S_WR  = 6'b100000
    } state_t;

    typedef enum logic [3:0] {
        K_PAGE,
        K_ST_IMM,
        K_ST_BR_IMM,
        K_LD_BR,
        K_CP_BR,
        K_LD_ABS,
        K_LD_HL,
        K_CP_HL_BR,
        K_CP_HL
    } kind_t;

    typedef enum logic [1:0] {
        D_HL,
        D_IX,
        D_IY
    } dst_t;

    typedef enum logic [1:0] {
        R_ACC = 2'b00,
        R_ACC2 = 2'b01,
        R_PTR_LO = 2'b10,
        R_PTR_HI = 2'b11
    } reg_sel_t;

endpackage

// >>> logic/byte_load_decoder.sv
// decode and execute of the 8-bit load group with data bus sequencing
`timescale 1ns/1ps
`include "byte_load_cfg.svh"

// Overview of operation
// - prefix then X page code loads next byte into x_data_page, 3 cycles
// - prefix then C7H loads next byte into y_data_page, 3 cycles
// - page loads are refused when the core runs small memory models
// - DDH, low byte, immediate: immediate written to base-plus-low, 4 cycles
// - base-plus-low address is base high byte over operand low byte
// - B5H with immediate stores it at pair_pointer, 3 cycles
// - B6H/B7H store immediate at index_x/index_y by low bit, 3 cycles
// - large models page index_x by x page and index_y by y page
// - large models page pointer and absolute forms by extended_page_sel
// - opcode bits 4:3, or bits 1:0 after the prefix, pick accumulator, second accumulator, low, high
// - 44H/4CH/54H/5CH with low byte load base-plus-low into register, 3 cycles
// - 6CH copies base-plus-low byte to pair_pointer location, 4 cycles
// - 64H/74H copy base-plus-low byte to index_x/index_y location, 4 cycles
// - prefix D0H-D3H, low then high byte, load 16-bit address, 5 cycles
// - 45H/4DH/55H/5DH load pair_pointer byte into register, 2 cycles
// - 7DH with low byte copies pair_pointer byte to base-plus-low, 4 cycles
// - 6DH copies pair_pointer byte onto itself in only 3 cycles
// - 65H/75H copy pair_pointer byte to index_x/index_y location, 3 cycles
module byte_load_decoder (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_wait,
    input wire logic i_large_model,
    input wire logic [7:0] i_code_byte,
    output logic o_fetch_req,
    input wire logic [7:0] i_base_high,
    input wire logic [15:0] i_pair_pointer,
    input wire logic [15:0] i_index_x,
    input wire logic [15:0] i_index_y,
    input wire logic [7:0] i_extended_page_sel,
    output logic [7:0] o_x_data_page,
    output logic [7:0] o_y_data_page,
    output logic [15:0] o_mem_addr,
    output logic [7:0] o_mem_page,
    output logic [7:0] o_mem_wdata,
    output logic o_mem_rd,
    output logic o_mem_wr,
    input wire logic [7:0] i_mem_rdata,
    output logic o_reg_we,
    output logic [1:0] o_reg_sel,
    output logic [7:0] o_reg_data,
    output logic o_flags_we,
    output logic o_unhandled,
    output logic o_unavail,
    output logic o_busy
);

    // ********************
    // state and decode signals
    // ********************
    byte_load_pkg::state_t state_r;
    byte_load_pkg::kind_t kind_r;
    byte_load_pkg::dst_t dst_r;
    logic [1:0] sel_r;
    logic page_y_r;
    logic [7:0] low_r;
    logic [7:0] x_page_r;
    logic [7:0] y_page_r;
    logic [15:0] addr_r;
    logic [7:0] page_r;
    logic [7:0] wdata_r;
    logic reg_we_r;
    logic [7:0] reg_data_r;
    logic unhandled_r;
    logic unavail_r;
    logic adv;
    logic [7:0] op;
    logic [15:0] dst_addr;
    logic [7:0] dst_page;
    logic [7:0] ext_page;

    // a wait from the bus freezes every step so cycle counts stay exact
    assign adv = !i_wait;
    assign op = i_code_byte;

    // small models have no page registers on the bus, page reads as zero
    assign ext_page = i_large_model ? i_extended_page_sel : `SMALL_PAGE;

    // destination pointer and its page for stores and copies
    always_comb begin
        unique case (dst_r)
            byte_load_pkg::D_IX: begin
                dst_addr = i_index_x;
                dst_page = i_large_model ? x_page_r : `SMALL_PAGE;
            end
            byte_load_pkg::D_IY: begin
                dst_addr = i_index_y;
                dst_page = i_large_model ? y_page_r : `SMALL_PAGE;
            end
            default: begin
                dst_addr = i_pair_pointer;
                dst_page = ext_page;
            end
        endcase
    end

    // ********************
    // sequencer: one state per core cycle
    // ********************
    // each instruction walks op, optional prefix/operands, then an optional read and an optional write
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= byte_load_pkg::S_OP;
        end else if (adv) begin
            unique case (state_r)
                byte_load_pkg::S_OP: begin
                    if (op == `OP_PREFIX) begin
                        state_r <= byte_load_pkg::S_PFX;
                    end else if (op == `OP_CP_HL_BR) begin
                        state_r <= byte_load_pkg::S_B1;
                    end else if (op == `OP_CP_HL_HL) begin
                        state_r <= byte_load_pkg::S_RD;
                    end else if ((op & `MASK_REG) == `OP_LD_HL ||
                                 (op & `MASK_IR_PTR) == `OP_CP_HL_IR) begin
                        state_r <= byte_load_pkg::S_RD;
                    end else if (op == `OP_ST_BR_IMM || op == `OP_ST_HL_IMM ||
                                 (op & `MASK_IR_IMM) == `OP_ST_IR_IMM ||
                                 (op & `MASK_REG) == `OP_LD_BR ||
                                 op == `OP_CP_BR_HL ||
                                 (op & `MASK_IR_PTR) == `OP_CP_BR_IR) begin
                        state_r <= byte_load_pkg::S_B1;
                    end
                end
                byte_load_pkg::S_PFX: begin
                    if (((op == `OP_PAGE_X || op == `OP_PAGE_Y) &&
                         i_large_model) ||
                        (op & `MASK_ABS) == `OP_LD_ABS) begin
                        state_r <= byte_load_pkg::S_B1;
                    end else begin
                        state_r <= byte_load_pkg::S_OP;
                    end
                end
                byte_load_pkg::S_B1: begin
                    unique case (kind_r)
                        byte_load_pkg::K_PAGE:
                            state_r <= byte_load_pkg::S_OP;
                        byte_load_pkg::K_ST_BR_IMM, byte_load_pkg::K_LD_ABS:
                            state_r <= byte_load_pkg::S_B2;
                        byte_load_pkg::K_ST_IMM:
                            state_r <= byte_load_pkg::S_WR;
                        default:
                            state_r <= byte_load_pkg::S_RD;
                    endcase
                end
                byte_load_pkg::S_B2: begin
                    if (kind_r == byte_load_pkg::K_ST_BR_IMM) begin
                        state_r <= byte_load_pkg::S_WR;
                    end else begin
                        state_r <= byte_load_pkg::S_RD;
                    end
                end
                byte_load_pkg::S_RD: begin
                    if (kind_r == byte_load_pkg::K_CP_BR ||
                        kind_r == byte_load_pkg::K_CP_HL_BR ||
                        kind_r == byte_load_pkg::K_CP_HL) begin
                        state_r <= byte_load_pkg::S_WR;
                    end else begin
                        state_r <= byte_load_pkg::S_OP;
                    end
                end
                default: state_r <= byte_load_pkg::S_OP;
            endcase
        end
    end

    // ********************
    // decode latches: kind, destination pointer, register field, low byte
    // ********************
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            kind_r <= byte_load_pkg::K_LD_HL;
            dst_r <= byte_load_pkg::D_HL;
            sel_r <= byte_load_pkg::R_ACC;
            page_y_r <= 1'b0;
            low_r <= `BYTE_RESET;
        end else if (adv) begin
            if (state_r == byte_load_pkg::S_OP) begin
                // register field sits in bits 4:3 for the load forms
                sel_r <= op[`REG_FIELD_HI:`REG_FIELD_LO];
                if (op == `OP_CP_HL_BR) begin
                    kind_r <= byte_load_pkg::K_CP_HL_BR;
                end else if (op == `OP_CP_HL_HL) begin
                    kind_r <= byte_load_pkg::K_CP_HL;
                    dst_r <= byte_load_pkg::D_HL;
                end else if ((op & `MASK_REG) == `OP_LD_HL) begin
                    kind_r <= byte_load_pkg::K_LD_HL;
                end else if ((op & `MASK_IR_PTR) == `OP_CP_HL_IR) begin
                    kind_r <= byte_load_pkg::K_CP_HL;
                    dst_r <= op[`IR_BIT_PTR] ? byte_load_pkg::D_IY :
                                               byte_load_pkg::D_IX;
                end else if (op == `OP_ST_BR_IMM) begin
                    kind_r <= byte_load_pkg::K_ST_BR_IMM;
                end else if (op == `OP_ST_HL_IMM) begin
                    kind_r <= byte_load_pkg::K_ST_IMM;
                    dst_r <= byte_load_pkg::D_HL;
                end else if ((op & `MASK_IR_IMM) == `OP_ST_IR_IMM) begin
                    kind_r <= byte_load_pkg::K_ST_IMM;
                    dst_r <= op[`IR_BIT_IMM] ? byte_load_pkg::D_IY :
                                               byte_load_pkg::D_IX;
                end else if ((op & `MASK_REG) == `OP_LD_BR) begin
                    kind_r <= byte_load_pkg::K_LD_BR;
                end else if (op == `OP_CP_BR_HL) begin
                    kind_r <= byte_load_pkg::K_CP_BR;
                    dst_r <= byte_load_pkg::D_HL;
                end else if ((op & `MASK_IR_PTR) == `OP_CP_BR_IR) begin
                    kind_r <= byte_load_pkg::K_CP_BR;
                    dst_r <= op[`IR_BIT_PTR] ? byte_load_pkg::D_IY :
                                               byte_load_pkg::D_IX;
                end
            end else if (state_r == byte_load_pkg::S_PFX) begin
                sel_r <= op[`ABS_FIELD_HI:`ABS_FIELD_LO];
                page_y_r <= op[`PAGE_SEL_BIT];
                if ((op & `MASK_ABS) == `OP_LD_ABS) begin
                    kind_r <= byte_load_pkg::K_LD_ABS;
                end else begin
                    kind_r <= byte_load_pkg::K_PAGE;
                end
            end else if (state_r == byte_load_pkg::S_B1) begin
                low_r <= op;
            end
        end
    end

    // ********************
    // page registers
    // ********************
    // the prefix state already refused these in small models
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            x_page_r <= `PAGE_RESET;
            y_page_r <= `PAGE_RESET;
        end else if (adv && state_r == byte_load_pkg::S_B1 &&
                     kind_r == byte_load_pkg::K_PAGE) begin
            if (page_y_r) begin
                y_page_r <= op;
            end else begin
                x_page_r <= op;
            end
        end
    end

    // ********************
    // bus address and page, set one cycle ahead so they leave flops
    // ********************
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            addr_r <= `ADDR_RESET;
            page_r <= `SMALL_PAGE;
        end else if (adv) begin
            if (state_r == byte_load_pkg::S_OP) begin
                // pointer reads start straight after the opcode
                addr_r <= i_pair_pointer;
                page_r <= ext_page;
            end else if (state_r == byte_load_pkg::S_B1) begin
                if (kind_r == byte_load_pkg::K_ST_IMM) begin
                    addr_r <= dst_addr;
                    page_r <= dst_page;
                end else if (kind_r == byte_load_pkg::K_CP_HL_BR) begin
                    addr_r <= i_pair_pointer;
                    page_r <= ext_page;
                end else begin
                    addr_r <= {i_base_high, op};
                    page_r <= ext_page;
                end
            end else if (state_r == byte_load_pkg::S_B2) begin
                if (kind_r == byte_load_pkg::K_ST_BR_IMM) begin
                    addr_r <= {i_base_high, low_r};
                end else begin
                    addr_r <= {op, low_r};
                end
                page_r <= ext_page;
            end else if (state_r == byte_load_pkg::S_RD) begin
                if (kind_r == byte_load_pkg::K_CP_HL_BR) begin
                    addr_r <= {i_base_high, low_r};
                    page_r <= ext_page;
                end else begin
                    // same address for the self copy, no extra cycle
                    addr_r <= dst_addr;
                    page_r <= dst_page;
                end
            end
        end
    end

    // ********************
    // write data: immediate from the stream or the byte just read
    // ********************
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wdata_r <= `BYTE_RESET;
        end else if (adv) begin
            if ((state_r == byte_load_pkg::S_B1 &&
                 kind_r == byte_load_pkg::K_ST_IMM) ||
                state_r == byte_load_pkg::S_B2) begin
                wdata_r <= op;
            end else if (state_r == byte_load_pkg::S_RD) begin
                wdata_r <= i_mem_rdata;
            end
        end
    end

    // ********************
    // register file write port and event pulses
    // ********************
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            reg_we_r <= 1'b0;
            reg_data_r <= `BYTE_RESET;
        end else begin
            reg_we_r <= adv && state_r == byte_load_pkg::S_RD &&
                        (kind_r == byte_load_pkg::K_LD_BR ||
                         kind_r == byte_load_pkg::K_LD_ABS ||
                         kind_r == byte_load_pkg::K_LD_HL);
            if (adv && state_r == byte_load_pkg::S_RD) begin
                reg_data_r <= i_mem_rdata;
            end
        end
    end

    // foreign codes after the prefix are flagged so the rest of the core can take them
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            unhandled_r <= 1'b0;
            unavail_r <= 1'b0;
        end else begin
            unhandled_r <= adv && state_r == byte_load_pkg::S_PFX &&
                           op != `OP_PAGE_X && op != `OP_PAGE_Y &&
                           (op & `MASK_ABS) != `OP_LD_ABS;
            unavail_r <= adv && state_r == byte_load_pkg::S_PFX &&
                         !i_large_model &&
                         (op == `OP_PAGE_X || op == `OP_PAGE_Y);
        end
    end

    // ********************
    // outputs
    // ********************
    assign o_fetch_req = state_r == byte_load_pkg::S_OP ||
                         state_r == byte_load_pkg::S_PFX ||
                         state_r == byte_load_pkg::S_B1 ||
                         state_r == byte_load_pkg::S_B2;
    assign o_mem_rd = state_r == byte_load_pkg::S_RD;
    assign o_mem_wr = state_r == byte_load_pkg::S_WR;
    assign o_busy = state_r != byte_load_pkg::S_OP;
    assign o_mem_addr = addr_r;
    assign o_mem_page = page_r;
    assign o_mem_wdata = wdata_r;
    assign o_x_data_page = x_page_r;
    assign o_y_data_page = y_page_r;
    assign o_reg_we = reg_we_r;
    assign o_reg_sel = sel_r;
    assign o_reg_data = reg_data_r;
    assign o_unhandled = unhandled_r;
    assign o_unavail = unavail_r;
    // the flag file is never written by this group
    assign o_flags_we = 1'b0;

endmodule

// >>> testbench/byte_load_props.sv
// concurrent checks on the byte load decoder ports
`timescale 1ns/1ps
module byte_load_props (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_wait,
    input wire logic i_large_model,
    input wire logic [7:0] i_code_byte,
    input wire logic o_fetch_req,
    input wire logic [7:0] i_base_high,
    input wire logic [15:0] i_pair_pointer,
    input wire logic [15:0] i_index_x,
    input wire logic [15:0] i_index_y,
    input wire logic [7:0] i_extended_page_sel,
    input wire logic [7:0] o_x_data_page,
    input wire logic [7:0] o_y_data_page,
    input wire logic [15:0] o_mem_addr,
    input wire logic [7:0] o_mem_page,
    input wire logic [7:0] o_mem_wdata,
    input wire logic o_mem_rd,
    input wire logic o_mem_wr,
    input wire logic [7:0] i_mem_rdata,
    input wire logic o_reg_we,
    input wire logic [1:0] o_reg_sel,
    input wire logic [7:0] o_reg_data,
    input wire logic o_flags_we,
    input wire logic o_unavail,
    input wire logic o_busy
);
    // ********************
    // helpers and checks
    // ********************
    logic tk;
    logic op;
    // code byte consumed; opcode consumed only outside a sequence
    assign tk = o_fetch_req && !i_wait;
    assign op = tk && !o_busy;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_page_load:
        assert property ((op && i_code_byte == 8'hce) ##1 (tk && i_large_model
            && i_code_byte[7:1] == 7'h63) ##1 tk |=> ($past(i_code_byte[0], 2)
            ? o_y_data_page : o_x_data_page) == $past(i_code_byte))
        else $error("page register not loaded");
    a_page_refused:
        assert property ((op && i_code_byte == 8'hce) ##1 (tk && !i_large_model
            && i_code_byte[7:1] == 7'h63) |=> o_unavail
            && $stable(o_x_data_page) && $stable(o_y_data_page))
        else $error("page load not refused");
    a_base_store:
        assert property ((op && i_code_byte == 8'hdd && i_large_model) ##1 tk
            ##1 tk |=> o_mem_wr && o_mem_wdata == $past(i_code_byte)
            && o_mem_addr == {$past(i_base_high), $past(i_code_byte, 2)}
            && o_mem_page == $past(i_extended_page_sel))
        else $error("base store wrong");
    a_index_store:
        assert property ((op && i_code_byte[7:1] == 7'h5b && i_large_model)
            ##1 tk |=> o_mem_wr && o_mem_wdata == $past(i_code_byte)
            && o_mem_addr == ($past(i_code_byte[0], 2) ? $past(i_index_y)
            : $past(i_index_x)) && o_mem_page == ($past(i_code_byte[0], 2)
            ? o_y_data_page : o_x_data_page))
        else $error("index store wrong");
    a_pair_load:
        assert property ((op && i_code_byte[7:5] == 3'b010 && i_large_model
            && i_code_byte[2:0] == 3'b101) |=> (o_mem_rd
            && o_mem_addr == $past(i_pair_pointer)
            && o_mem_page == $past(i_extended_page_sel))
            ##1 (o_reg_we && o_reg_sel == $past(i_code_byte[4:3], 2)))
        else $error("pair load wrong");
    a_abs_load:
        assert property ((op && i_code_byte == 8'hce) ##1 (tk
            && i_code_byte[7:2] == 6'h34) ##1 tk ##1 tk |=> (o_mem_rd
            && o_mem_addr == {$past(i_code_byte), $past(i_code_byte, 2)})
            ##1 (o_reg_we && o_reg_sel == $past(i_code_byte[1:0], 4)))
        else $error("absolute load wrong");
    a_read_passed:
        assert property (o_mem_rd && !i_wait |=> (o_reg_we
            && o_reg_data == $past(i_mem_rdata)) || (o_mem_wr
            && o_mem_wdata == $past(i_mem_rdata)))
        else $error("read byte not passed on");
    a_self_copy:
        assert property ((op && i_code_byte == 8'h6d) |=> o_mem_rd
            ##1 (o_mem_wr && $stable(o_mem_addr)) ##1 !o_busy)
        else $error("self copy timing wrong");
    a_flags_kept:
        assert property (o_flags_we == 1'b0)
        else $error("flags written");
endmodule

bind byte_load_decoder byte_load_props u_props (.*);

// >>> testbench/data_mem_model.sv
// paged data memory answering the decoder bus cycles
`timescale 1ns/1ps
module data_mem_model (
    input wire logic i_mclk,
    input wire logic [7:0] i_page,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd,
    input wire logic i_wr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [int];
    logic [7:0] last_r = 8'h00;
    int writes = 0;
    // idle bus shows the inverse of the last byte so stale data never passes
    always @* begin
        if (i_rd) begin
            o_rdata = mem.exists(int'({i_page, i_addr}))
                ? mem[int'({i_page, i_addr})] : 8'hee;
        end else begin
            o_rdata = ~last_r;
        end
    end
    // writes land at the closing edge of the write cycle
    always @(posedge i_mclk) begin
        last_r <= o_rdata;
        if (i_wr === 1'b1) begin
            mem[int'({i_page, i_addr})] = i_wdata;
            writes++;
        end
    end
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the byte load decoder
`timescale 1ns/1ps
module tb_top;
    logic i_mclk = 0;
    logic i_rst = 1;
    logic i_wait = 0;
    logic i_large_model = 1;
    logic [7:0] i_code_byte = 8'h00;
    logic [7:0] i_base_high = 8'h12;
    logic [15:0] i_pair_pointer = 16'h3456;
    logic [15:0] i_index_x = 16'h789a;
    logic [15:0] i_index_y = 16'hbcde;
    logic [7:0] i_extended_page_sel = 8'h05;
    logic [7:0] i_mem_rdata, o_x_data_page, o_y_data_page, o_mem_page;
    logic [7:0] o_mem_wdata, o_reg_data;
    logic [15:0] o_mem_addr;
    logic [1:0] o_reg_sel, seen_sel;
    logic o_fetch_req, o_mem_rd, o_mem_wr, o_reg_we, o_flags_we;
    logic o_unhandled, o_unavail, o_busy;
    logic [7:0] seen_data;
    int miscompares = 0;
    int samples_checked = 0;
    int unavail_seen = 0;
    int unhandled_seen = 0;

    byte_load_decoder u_dut (.*);
    data_mem_model u_mem (.i_mclk(i_mclk), .i_page(o_mem_page),
        .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_rd(o_mem_rd),
        .i_wr(o_mem_wr), .o_rdata(i_mem_rdata));

    // ********************
    // clock and monitors
    // ********************
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    // register pulses last one cycle, so catch them at their edge
    always @(posedge i_mclk) begin
        if (o_reg_we === 1'b1) begin
            seen_sel = o_reg_sel;
            seen_data = o_reg_data;
        end
        if (o_unavail === 1'b1) unavail_seen++;
        if (o_unhandled === 1'b1) unhandled_seen++;
    end

    // ********************
    // shared tasks
    // ********************
    task automatic check(input string what, input logic [15:0] got,
            input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // a byte is offered once the decoder asks for one, or after 20 cycles of waiting without a request
    task automatic feed(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge i_mclk);
        while (o_fetch_req !== 1'b1 && n < 20) begin
            @(negedge i_mclk);
            n++;
        end
        i_code_byte = b;
        @(posedge i_mclk);
    endtask
    // a filler opcode proves the previous instruction has ended
    task automatic finish();
        feed(8'h00);
        @(negedge i_mclk);
    endtask
    function automatic logic [7:0] at(input logic [7:0] p,
            input logic [15:0] a);
        return u_mem.mem.exists(int'({p, a})) ? u_mem.mem[int'({p, a})]
            : 8'hee;
    endfunction
    task automatic poke(input logic [15:0] a, input logic [7:0] v);
        u_mem.mem[int'({8'h05, a})] = v;
    endtask

    // ********************
    // scenarios
    // ********************
    task automatic t_pages();
        feed(8'hce); feed(8'hc6); feed(8'h11);
        feed(8'hce); feed(8'hc7); feed(8'h22);
        finish();
        check("x page", 16'(o_x_data_page), 16'h0011);
        check("y page", 16'(o_y_data_page), 16'h0022);
        i_large_model = 0;
        feed(8'hce); feed(8'hc6); feed(8'h33);
        finish();
        check("x page kept", 16'(o_x_data_page), 16'h0011);
        check("refusals", 16'(unavail_seen), 16'h0001);
        feed(8'hce); feed(8'h12); finish();
        check("foreign", 16'(unhandled_seen), 16'h0001);
        i_large_model = 1;
    endtask
    task automatic t_stores();
        feed(8'hdd); feed(8'h40); feed(8'ha1); finish();
        check("base store", 16'(at(8'h05, 16'h1240)), 16'h00a1);
        feed(8'hb5); feed(8'ha2); finish();
        check("pair store", 16'(at(8'h05, 16'h3456)), 16'h00a2);
        feed(8'hb6); feed(8'ha3); feed(8'hb7); feed(8'ha4); finish();
        check("x store", 16'(at(8'h11, 16'h789a)), 16'h00a3);
        check("y store", 16'(at(8'h22, 16'hbcde)), 16'h00a4);
    endtask
    task automatic t_loads();
        logic [1:0] s;
        for (int r = 0; r < 4; r++) begin
            s = 2'(r);
            poke(16'h1260, 8'h30 + 8'(r));
            feed(8'h44 | {3'h0, s, 3'h0}); feed(8'h60); finish();
            check("base sel", 16'(seen_sel), 16'(s));
            check("base data", 16'(seen_data), 16'h30 + 16'(r));
            poke(16'h3456, 8'h40 + 8'(r));
            feed(8'h45 | {3'h0, s, 3'h0}); finish();
            check("pair data", 16'(seen_data), 16'h40 + 16'(r));
            poke(16'h9a7b, 8'h50 + 8'(r));
            feed(8'hce); feed(8'hd0 | {6'h0, s}); feed(8'h7b); feed(8'h9a);
            finish();
            check("abs sel", 16'(seen_sel), 16'(s));
            check("abs data", 16'(seen_data), 16'h50 + 16'(r));
        end
    endtask
    task automatic t_copies();
        int n;
        poke(16'h1270, 8'h61);
        feed(8'h6c); feed(8'h70); finish();
        check("to pair", 16'(at(8'h05, 16'h3456)), 16'h0061);
        poke(16'h1271, 8'h62);
        feed(8'h64); feed(8'h71); feed(8'h74); feed(8'h71); finish();
        check("to x", 16'(at(8'h11, 16'h789a)), 16'h0062);
        check("to y", 16'(at(8'h22, 16'hbcde)), 16'h0062);
        poke(16'h3456, 8'h63);
        feed(8'h7d); feed(8'h72); finish();
        check("to base", 16'(at(8'h05, 16'h1272)), 16'h0063);
        n = u_mem.writes;
        feed(8'h6d); finish();
        check("self writes", 16'(u_mem.writes - n), 16'h0001);
        feed(8'h65); feed(8'h75); finish();
        check("pair to x", 16'(at(8'h11, 16'h789a)), 16'h0063);
        check("pair to y", 16'(at(8'h22, 16'hbcde)), 16'h0063);
    endtask
    // a stall between opcode and immediate must not lose the byte
    task automatic t_stall();
        feed(8'hb5);
        @(negedge i_mclk);
        i_wait = 1;
        i_code_byte = 8'hff;
        repeat (3) @(negedge i_mclk);
        i_code_byte = 8'h5c;
        i_wait = 0;
        @(posedge i_mclk);
        finish();
        check("stalled store", 16'(at(8'h05, 16'h3456)), 16'h005c);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst = 0;
        t_pages();
        t_stores();
        t_loads();
        t_copies();
        t_stall();
        complete_run();
    end
    // the whole sequence needs under two hundred cycles; allow ample margin
    initial begin
        #20000;
        miscompares++;
        complete_run();
    end
endmodule
